// File: fgtb_pkg.sv
// Package: register map, field layout and defaults of the fine gain trim bank
package fgtb_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          NUM_REGS      = 8;
    localparam int          REG_W         = 8;
    localparam int          CODE_W        = 5;
    localparam int          CODE_LSB      = 0;
    localparam int          CODE_MSB      = 4;
    localparam int          RSVD_LSB      = 5;
    localparam int          RSVD_MSB      = 7;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] BASE_INDEX    = 12'h360;
    localparam logic [11:0] IDX_CORE0     = 12'h360;
    localparam logic [11:0] IDX_CORE1     = 12'h361;
    localparam logic [11:0] IDX_CORE2_A   = 12'h362;
    localparam logic [11:0] IDX_CORE2_B   = 12'h363;
    localparam logic [11:0] IDX_CORE3_C   = 12'h364;
    localparam logic [11:0] IDX_CORE3_D   = 12'h365;
    localparam logic [11:0] IDX_CORE4     = 12'h366;
    localparam logic [11:0] IDX_CORE5     = 12'h367;
    localparam logic [2:0]  SLOT_CORE0    = 3'h0;
    localparam logic [2:0]  SLOT_CORE1    = 3'h1;
    localparam logic [2:0]  SLOT_CORE2_A  = 3'h2;
    localparam logic [2:0]  SLOT_CORE2_B  = 3'h3;
    localparam logic [2:0]  SLOT_CORE3_C  = 3'h4;
    localparam logic [2:0]  SLOT_CORE3_D  = 3'h5;
    localparam logic [2:0]  SLOT_CORE4    = 3'h6;
    localparam logic [2:0]  SLOT_CORE5    = 3'h7;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// File: fgtb_if.sv
// Interface: trim register storage port between bank and slave
`timescale 1ns/1ps
interface fgtb_if;
    logic [2:0] wr_slot;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [2:0] rd_slot;
    logic [7:0] rd_data;
    logic [63:0] all_regs;
    logic       loaded;
    modport bank  (input wr_slot, wr_en, wr_data, rd_slot, output rd_data, all_regs, loaded);
    modport slave (output wr_slot, wr_en, wr_data, rd_slot, input rd_data, all_regs, loaded);
endinterface

// File: fgtb_store.sv
// Trim register storage with fuse-loaded defaults
`timescale 1ns/1ps
module fgtb_store (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [63:0] fuse_values,
    input  wire logic        fuse_valid,
    fgtb_if.bank             st
);
    logic [7:0] regs [8];
    logic       loaded;

    assign st.rd_data  = regs[st.rd_slot];
    assign st.loaded   = loaded;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_reg
            assign st.all_regs[g*8 +: 8] = regs[g];
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    regs[g] <= fgtb_pkg::REG_RESET;
                end else if (!loaded && fuse_valid) begin
                    // Fuse copy taken once after reset release, not at reset
                    regs[g] <= fuse_values[g*8 +: 8];
                end else if (st.wr_en && st.wr_slot == 3'(g)) begin
                    regs[g] <= st.wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rstn) begin
            loaded <= 1'b0;
        end else if (fuse_valid) begin
            loaded <= 1'b1;
        end
    end
endmodule // fgtb_store

// File: fgtb_bank.sv
// Top: fine gain trim bank with Avalon-MM slave and per-core code outputs
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module fgtb_bank (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [13:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [63:0] fuse_values,
    input  wire logic        fuse_valid,
    input  wire logic        core2_on_pair_b,
    input  wire logic        core3_on_pair_d,
    output logic      [4:0]  converter_core_0_gain,
    output logic      [4:0]  converter_core_1_gain,
    output logic      [4:0]  converter_core_2_gain,
    output logic      [4:0]  converter_core_3_gain,
    output logic      [4:0]  converter_core_4_gain,
    output logic      [4:0]  converter_core_5_gain
);
    ////////////////////////////////////////////////////////////////////////////
    fgtb_if st ();

    fgtb_store u_store (
        .clock       (clock),
        .rstn        (rstn),
        .fuse_values (fuse_values),
        .fuse_valid  (fuse_valid),
        .st          (st)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode: word index in address bits 13:2
    wire  [11:0] word_index = avs_address[13:2];
    wire         hit        = (word_index >= fgtb_pkg::BASE_INDEX) &&
                              (word_index <= fgtb_pkg::IDX_CORE5);
    wire  [11:0] rel_index  = word_index - fgtb_pkg::BASE_INDEX;
    wire  [2:0]  slot       = rel_index[2:0];

    // One wait cycle per access; answer on second cycle. Bus stalls until fuses land
    logic ack;
    wire  req  = avs_read || avs_write;
    wire  take = req && ack;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack && st.loaded;
        end
    end

    assign avs_waitrequest = req && !ack;

    // Only lane 0 carries data; reserved bits stored as written
    assign st.wr_slot = slot;
    assign st.wr_en   = take && avs_write && hit && avs_byteenable[0];
    assign st.wr_data = avs_writedata[7:0];
    assign st.rd_slot = slot;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            avs_readdata <= fgtb_pkg::UNMAPPED_READ;
        end else if (req && !ack) begin
            avs_readdata <= hit ? {24'h000000, st.rd_data} : fgtb_pkg::UNMAPPED_READ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] code_of(input logic [63:0] r, input logic [2:0] s);
        logic [7:0] b;
        b = r[s*8 +: 8];
        return b[fgtb_pkg::CODE_MSB:fgtb_pkg::CODE_LSB];
    endfunction

    wire [63:0] r = st.all_regs;

    // Reserved bits 7:5 never reach the gain path, whatever software wrote
    always_ff @(posedge clock) begin
        if (!rstn) begin
            converter_core_0_gain <= 5'h00;
            converter_core_1_gain <= 5'h00;
            converter_core_2_gain <= 5'h00;
            converter_core_3_gain <= 5'h00;
            converter_core_4_gain <= 5'h00;
            converter_core_5_gain <= 5'h00;
        end else begin
            converter_core_0_gain <= code_of(r, fgtb_pkg::SLOT_CORE0);
            converter_core_1_gain <= code_of(r, fgtb_pkg::SLOT_CORE1);
            converter_core_2_gain <= core2_on_pair_b ?
                                     code_of(r, fgtb_pkg::SLOT_CORE2_B) :
                                     code_of(r, fgtb_pkg::SLOT_CORE2_A);
            converter_core_3_gain <= core3_on_pair_d ?
                                     code_of(r, fgtb_pkg::SLOT_CORE3_D) :
                                     code_of(r, fgtb_pkg::SLOT_CORE3_C);
            converter_core_4_gain <= code_of(r, fgtb_pkg::SLOT_CORE4);
            converter_core_5_gain <= code_of(r, fgtb_pkg::SLOT_CORE5);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_core0_code: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> converter_core_0_gain == $past(r[4:0]))
        else $error("core0 gain wrong");
    a_core1_code: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> converter_core_1_gain == $past(r[12:8]))
        else $error("core1 gain wrong");
    a_core2_pair_a: assert property (@(posedge clock) disable iff (!rstn)
        !core2_on_pair_b |=> converter_core_2_gain == $past(r[20:16]))
        else $error("core2 pair a gain wrong");
    a_core2_pair_b: assert property (@(posedge clock) disable iff (!rstn)
        core2_on_pair_b |=> converter_core_2_gain == $past(r[28:24]))
        else $error("core2 pair b gain wrong");
    a_core3_pair_c: assert property (@(posedge clock) disable iff (!rstn)
        !core3_on_pair_d |=> converter_core_3_gain == $past(r[36:32]))
        else $error("core3 pair c gain wrong");
    a_core3_pair_d: assert property (@(posedge clock) disable iff (!rstn)
        core3_on_pair_d |=> converter_core_3_gain == $past(r[44:40]))
        else $error("core3 pair d gain wrong");
    a_core4_code: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> converter_core_4_gain == $past(r[52:48]))
        else $error("core4 gain wrong");
    a_core5_code: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> converter_core_5_gain == $past(r[60:56]))
        else $error("core5 gain wrong");
    a_fuse_load: assert property (@(posedge clock) disable iff (!rstn)
        (fuse_valid && !st.loaded) |=> r == $past(fuse_values))
        else $error("fuse defaults not loaded");
    a_write_read: assert property (@(posedge clock) disable iff (!rstn)
        st.wr_en |=> st.all_regs[$past(slot)*8 +: 8] == $past(avs_writedata[7:0]))
        else $error("write not stored");
    a_map_range: assert property (@(posedge clock) disable iff (!rstn)
        (avs_read && !ack && !hit) |=> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // fgtb_bank

// File: test_fgtb_bank.sv
// Testbench: bus access, fuse defaults and gain selection of the fine gain trim bank
`timescale 1ns/1ps
module test_fgtb_bank;
    logic        clock           = 1'b0;
    logic        rstn            = 1'b0;
    logic [13:0] avs_address     = 14'h0000;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h00000000;
    logic [3:0]  avs_byteenable  = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [63:0] fuse_values     = 64'he31f0aa7c2151e08;
    logic        fuse_valid      = 1'b0;
    logic        core2_on_pair_b = 1'b0;
    logic        core3_on_pair_d = 1'b0;
    logic [4:0]  g0, g1, g2, g3, g4, g5;
    logic [7:0]  model [8];
    logic [31:0] q;
    int          mismatches      = 0;
    int          n_tests         = 0;

    always #4 clock = ~clock;

    fgtb_bank uut (.clock(clock), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fuse_values(fuse_values),
        .fuse_valid(fuse_valid), .core2_on_pair_b(core2_on_pair_b),
        .core3_on_pair_d(core3_on_pair_d), .converter_core_0_gain(g0),
        .converter_core_1_gain(g1), .converter_core_2_gain(g2), .converter_core_3_gain(g3),
        .converter_core_4_gain(g4), .converter_core_5_gain(g5));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Only the low five bits steer the gain; reserved bits never reach it
    task automatic chk_gain(input logic [4:0] got, input logic [7:0] exp);
        chk_data({27'h0, got}, {27'h0, exp[4:0]});
    endtask

    function automatic logic [13:0] addr(input int g);
        return {fgtb_pkg::BASE_INDEX + 12'(g), 2'b00};
    endfunction

    // Entered just after a rising edge; leaves one idle edge so drivers never double-assign
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        if (i == 40) begin
            mismatches++;
            complete_run();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic check_gains;
        repeat (2) @(posedge clock);
        chk_gain(g0, model[0]);
        chk_gain(g1, model[1]);
        if (core2_on_pair_b) chk_gain(g2, model[3]);
        else chk_gain(g2, model[2]);
        if (core3_on_pair_d) chk_gain(g3, model[5]);
        else chk_gain(g3, model[4]);
        chk_gain(g4, model[6]);
        chk_gain(g5, model[7]);
    endtask

    task automatic read_all;
        for (int g = 0; g < 8; g++) begin
            bus(1'b0, addr(g), 32'h0, 4'hf, q);
            chk_data(q, {24'h0, model[g]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic scn_fuse_load;
        chk_gain(g0, 8'h00);
        fork
            begin
                repeat (4) @(posedge clock);
                chk_data({31'h0, avs_waitrequest}, 32'h1);
                fuse_valid <= 1'b1;
            end
            bus(1'b0, addr(0), 32'h0, 4'hf, q);
        join
        chk_data(q, {24'h0, fuse_values[7:0]});
        for (int g = 0; g < 8; g++) model[g] = fuse_values[8*g +: 8];
        read_all();
        check_gains();
    endtask

    task automatic scn_write_all;
        for (int g = 0; g < 8; g++) begin
            model[g] = 8'h1f - 8'(g * 3);
            bus(1'b1, addr(g), {24'ha5a5a5, model[g]}, 4'hf, q);
        end
        read_all();
        check_gains();
    endtask

    task automatic scn_pair_select;
        for (int s = 0; s < 4; s++) begin
            core2_on_pair_b <= s[0];
            core3_on_pair_d <= s[1];
            check_gains();
        end
    endtask

    // Refused writes, unmapped reads, and a late fuse change must leave the bank alone
    task automatic scn_refused;
        fuse_values <= ~fuse_values;
        bus(1'b1, addr(0), 32'h00000015, 4'he, q);
        bus(1'b1, addr(8), 32'h0000000b, 4'hf, q);
        bus(1'b0, addr(8), 32'h0, 4'hf, q);
        chk_data(q, fgtb_pkg::UNMAPPED_READ);
        bus(1'b0, addr(-1), 32'h0, 4'hf, q);
        chk_data(q, fgtb_pkg::UNMAPPED_READ);
        read_all();
        check_gains();
    endtask

    // Mid-run reset: gains clear, then the (now inverted) fuse copy is taken again
    task automatic scn_reset;
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        chk_gain(g0, 8'h00);
        rstn <= 1'b1;
        for (int g = 0; g < 8; g++) model[g] = fuse_values[8*g +: 8];
        read_all();
        check_gains();
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        scn_fuse_load();
        scn_write_all();
        scn_pair_select();
        scn_refused();
        scn_reset();
        complete_run();
    end
endmodule // test_fgtb_bank
